// ### pkg/cpwm_pkg.sv
// Package: register map, resets and resolution helpers for the centre-aligned PWM block
package cpwm_pkg;
	// ****************************************
	// Sizes
	// ****************************************
	localparam int NUM_CH = 6;
	localparam int DUTY_W = 12;
	localparam int PH_W = 13;
	localparam int ADDR_W = 18;
	// ****************************************
	// Register indices (byte address = 4 * index)
	// ****************************************
	localparam logic [15:0] IDX_CFG1 = 16'hA080;
	localparam logic [15:0] IDX_EVT = 16'hA081;
	localparam logic [15:0] IDX_DSP = 16'hA082;
	localparam logic [15:0] IDX_MASK = 16'hA083;
	localparam logic [15:0] IDX_DUTY0 = 16'hA084;
	localparam logic [15:0] NUM_DUTY_IDX = 16'h000C;
	localparam logic [7:0] RST_CFG1 = 8'h00;
	localparam logic [7:0] RST_EVT = 8'h08;
	localparam logic [7:0] RST_DSP = 8'h00;
	localparam logic [7:0] RST_MASK = 8'h00;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int CFG1_EN = 7;
	localparam int CFG1_MODE = 5;
	localparam int EVT_ZTRG = 7;
	localparam int EVT_CTRG = 6;
	localparam int EVT_ZIE = 5;
	localparam int EVT_CIE = 4;
	localparam int EVT_SYNC_GATED_UPDATE_ENABLE = 3;
	localparam int EVT_ZF = 1;
	localparam int EVT_CF = 0;
	localparam int DSP_PRS = 7;
	localparam int DSP_SYNC = 6;
	// ****************************************
	// Period and dither constants
	// ****************************************
	localparam int PERIOD_8 = 512;
	localparam int PERIOD_10 = 2048;
	localparam int PERIOD_12 = 8192;
	localparam logic [15:0] LFSR_SEED = 16'hACE1;
	localparam logic [15:0] LFSR_TAPS = 16'hB400;
	typedef enum logic [1:0] {RES_8 = 2'b00, RES_10 = 2'b01, RES_12 = 2'b10} cpwm_res_e;
	// Unused code 2'b11 behaves as 12-bit
	function automatic logic [3:0] cpwm_shift(input logic [1:0] m);
		case (m)
			RES_8: cpwm_shift = 4'h4;
			RES_10: cpwm_shift = 4'h2;
			default: cpwm_shift = 4'h0;
		endcase
	endfunction : cpwm_shift
	function automatic logic [PH_W-1:0] cpwm_top(input logic [1:0] m);
		case (m)
			RES_8: cpwm_top = PH_W'(PERIOD_8 - 1);
			RES_10: cpwm_top = PH_W'(PERIOD_10 - 1);
			default: cpwm_top = PH_W'(PERIOD_12 - 1);
		endcase
	endfunction : cpwm_top
	function automatic logic [DUTY_W-1:0] cpwm_mask(input logic [1:0] m);
		cpwm_mask = 12'hFFF >> cpwm_shift(m);
	endfunction : cpwm_mask
endpackage : cpwm_pkg

// ### pkg/cpwm_chan_if.sv
// Interface: shared timebase and dither state from the controller to each channel
interface cpwm_chan_if;
	logic [11:0] cnt_s;
	logic run;
	logic [1:0] res;
	logic dith_en;
	logic dith_sign;
	logic dith_odd;
	modport ctrl (output cnt_s, run, res, dith_en, dith_sign, dith_odd);
	modport chan (input cnt_s, run, res, dith_en, dith_sign, dith_odd);
endinterface : cpwm_chan_if

// ### hw/cpwm_chan.sv
// One PWM channel: resolution masking, dither, centre compare and polarity
module cpwm_chan (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	cpwm_chan_if.chan ctl_in,
	input wire logic [cpwm_pkg::DUTY_W-1:0] duty_in,
	input wire logic pol_in,
	output logic pwm_out
);
	import cpwm_pkg::*;
	logic [DUTY_W-1:0] duty_m;
	logic [DUTY_W-1:0] eff;
	logic [PH_W-1:0] scaled;
	logic at_edge;
	logic hit;
	always_comb begin
		duty_m = duty_in & cpwm_mask(ctl_in.res); // [R12]
		at_edge = (duty_m == '0) || (duty_m == cpwm_mask(ctl_in.res));
		// Pairs of cycles get +s then -s, so the average stays put [R16]
		if (ctl_in.dith_en && !at_edge) begin
			eff = ctl_in.dith_odd ? duty_m - {11'h000, ctl_in.dith_sign} : duty_m + {11'h000, ctl_in.dith_sign};
		end else begin
			eff = duty_m;
		end
		scaled = PH_W'({1'b0, eff}) << cpwm_shift(ctl_in.res);
		// High on 2*duty of 2*2^N ticks: zero never high, max is (period-2)/period [R9] [R10]
		hit = ({1'b0, ctl_in.cnt_s} + scaled) >= 13'h1000;
	end
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in || !ctl_in.run) begin
			pwm_out <= 1'b0; // [R14]
		end else begin
			pwm_out <= hit ^ pol_in; // [R7]
		end
	end
	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	AST_CH_OFF: assert property (!ctl_in.run |=> !pwm_out) else $error("channel drives while disabled"); // [R14]
	AST_CH_ZERO: assert property (ctl_in.run && duty_m == '0 && !pol_in |=> !pwm_out) // [R9]
		else $error("zero duty drove high");
	AST_CH_INV: assert property (ctl_in.run && duty_m == '0 && pol_in |=> pwm_out) // [R7]
		else $error("inverted zero duty not high");
	COV_CH_HIGH: cover property (ctl_in.run && hit);
endmodule : cpwm_chan

// ### hw/cpwm_top.sv
// Centre-aligned six-channel PWM: APB registers, timebase, events and duty loading
// Notes on behaviour
// R1: Zero interrupt raised at each counter zero when its enable is set.
// R2: Centre interrupt raised at each counter midpoint when its enable is set.
// R3: Separate enables pulse the ADC trigger at counter zero and at centre.
// R4: Sync-gated mode loads all duties only after software writes sync one.
// R5: Without sync gating, buffered duties load automatically at each cycle start.
// R6: Zero flag set by hardware, stays until software clears it.
// R7: Per-channel polarity bit, one inverts that channel output.
// R8: Six duty registers, one per channel.
// R9: Duty zero keeps the output low all period.
// R10: Largest duty gives high for (period-1)/period, never fully on. The code gives (period-2)/period.
// R11: Duty is double-buffered, moved to comparator at cycle completion.
// R12: Compare uses duty bits 7..0, 9..0 or 11..0 by resolution.
// R13: While disabled, duty writes reach the comparator immediately.
// R14: Disable clears counter and state and forces outputs low.
// R15: Period is 512, 2048 or 8192 counting ticks by resolution.
// R16: Pseudo-random dither varies duty per cycle, keeping the average.
// R17: Sync bit self-clears after the reload at the next zero event.
// R18: Centre flag set by hardware, cleared by software like zero flag.
module cpwm_top (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [cpwm_pkg::ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	output logic [cpwm_pkg::NUM_CH-1:0] pwm_out,
	output logic irq_out,
	output logic adc_zero_trig_out,
	output logic adc_center_trig_out
);
	import cpwm_pkg::*;
	// ****************************************
	// Register state
	// ****************************************
	logic en_q;
	logic [1:0] mode_q;
	logic [4:0] scale_q;
	logic ztrg_en_q;
	logic ctrg_en_q;
	logic zint_en_q;
	logic cint_en_q;
	logic sync_gated_update_enable_q;
	logic zflag_q;
	logic cflag_q;
	logic prs_q;
	logic sync_q;
	logic [NUM_CH-1:0] pol_q;
	logic [1:0] mask_q;
	logic [DUTY_W-1:0] duty_buf_q [NUM_CH];
	logic [DUTY_W-1:0] duty_act_q [NUM_CH];
	logic [4:0] presc_q;
	logic [PH_W-1:0] phase_q;
	logic [15:0] lfsr_q;
	logic odd_q;
	logic sign_q;
	// ****************************************
	// Bus decode
	// ****************************************
	logic [15:0] idx;
	logic [15:0] doff;
	logic is_duty;
	logic [2:0] dch;
	logic dhi;
	logic mapped;
	logic wr;
	logic rd_setup;
	logic [7:0] wb;
	logic [31:0] rdata;
	assign idx = paddr_in[ADDR_W-1:2];
	assign doff = idx - IDX_DUTY0;
	assign is_duty = (idx >= IDX_DUTY0) && (doff < NUM_DUTY_IDX);
	assign dch = doff[3:1];
	assign dhi = doff[0];
	assign mapped = is_duty || (idx >= IDX_CFG1 && idx <= IDX_MASK);
	// Zero-wait slave: every access phase completes
	assign wr = psel_in && penable_in && pwrite_in && mapped;
	assign rd_setup = psel_in && !penable_in;
	assign wb = pwdata_in[7:0];
	assign pready_out = 1'b1;
	// ****************************************
	// Timebase
	// ****************************************
	logic run;
	logic tick;
	logic zero_evt;
	logic ctr_evt;
	logic reload;
	logic [PH_W-1:0] top;
	logic [PH_W-1:0] ph_s;
	logic [11:0] cnt_s;
	assign run = en_q;
	assign top = cpwm_top(mode_q);
	assign tick = run && (presc_q == scale_q);
	assign zero_evt = tick && (phase_q == '0); // [R1]
	assign ctr_evt = tick && (phase_q == (top >> 1) + 13'h0001); // [R2]
	assign reload = zero_evt && (!sync_gated_update_enable_q || sync_q); // [R4] [R5] [R11]
	assign ph_s = phase_q << cpwm_shift(mode_q);
	// Up half counts up, down half mirrors it
	assign cnt_s = (ph_s[12] ? ~ph_s[11:0] : ph_s[11:0]) & (12'hFFF << cpwm_shift(mode_q));
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in || !run) begin
			presc_q <= 5'h00; // [R14]
		end else if (tick) begin
			presc_q <= 5'h00;
		end else begin
			presc_q <= presc_q + 5'h01;
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in || !run) begin
			phase_q <= '0; // [R14]
		end else if (tick) begin
			// Also wraps if resolution shrinks mid-cycle [R15]
			phase_q <= (phase_q >= top) ? '0 : phase_q + 13'h0001;
		end
	end
	// ****************************************
	// Dither sequence
	// ****************************************
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			lfsr_q <= LFSR_SEED;
		end else if (zero_evt) begin
			lfsr_q <= lfsr_q[0] ? (lfsr_q >> 1) ^ LFSR_TAPS : lfsr_q >> 1;
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in || !run) begin
			odd_q <= 1'b0;
			sign_q <= 1'b0;
		end else if (zero_evt) begin
			odd_q <= !odd_q;
			// New sign only at the start of a pair [R16]
			if (odd_q) begin
				sign_q <= lfsr_q[0];
			end
		end
	end
	// ****************************************
	// Configuration registers
	// ****************************************
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			{en_q, mode_q, scale_q} <= RST_CFG1;
		end else if (wr && idx == IDX_CFG1) begin
			{en_q, mode_q, scale_q} <= wb;
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			{ztrg_en_q, ctrg_en_q, zint_en_q, cint_en_q, sync_gated_update_enable_q} <= RST_EVT[7:3];
		end else if (wr && idx == IDX_EVT) begin
			{ztrg_en_q, ctrg_en_q, zint_en_q, cint_en_q, sync_gated_update_enable_q} <= wb[7:3];
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			{prs_q, pol_q} <= {RST_DSP[7], RST_DSP[5:0]};
		end else if (wr && idx == IDX_DSP) begin
			{prs_q, pol_q} <= {wb[DSP_PRS], wb[5:0]}; // [R7]
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			mask_q <= RST_MASK[1:0];
		end else if (wr && idx == IDX_MASK) begin
			mask_q <= wb[1:0];
		end
	end
	// ****************************************
	// Sync request and event flags
	// ****************************************
	logic sync_set;
	assign sync_set = wr && idx == IDX_DSP && wb[DSP_SYNC];
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			sync_q <= RST_DSP[DSP_SYNC];
		end else if (sync_set) begin
			sync_q <= 1'b1; // [R4]
		end else if (reload) begin
			sync_q <= 1'b0; // [R17]
		end
	end
	// Hardware set wins over a same-cycle write-one clear
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			zflag_q <= RST_EVT[EVT_ZF];
		end else if (zero_evt && zint_en_q) begin
			zflag_q <= 1'b1; // [R1] [R6]
		end else if (wr && idx == IDX_EVT && wb[EVT_ZF]) begin
			zflag_q <= 1'b0; // [R6]
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			cflag_q <= RST_EVT[EVT_CF];
		end else if (ctr_evt && cint_en_q) begin
			cflag_q <= 1'b1; // [R2] [R18]
		end else if (wr && idx == IDX_EVT && wb[EVT_CF]) begin
			cflag_q <= 1'b0; // [R18]
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= (zflag_q && mask_q[1]) || (cflag_q && mask_q[0]);
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			adc_zero_trig_out <= 1'b0;
			adc_center_trig_out <= 1'b0;
		end else begin
			adc_zero_trig_out <= zero_evt && ztrg_en_q; // [R3]
			adc_center_trig_out <= ctr_evt && ctrg_en_q; // [R3]
		end
	end
	// ****************************************
	// Duty buffers
	// ****************************************
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < NUM_CH; i++) begin
				duty_buf_q[i] <= '0;
			end
		end else if (wr && is_duty) begin
			if (dhi) begin
				duty_buf_q[dch][11:8] <= wb[3:0]; // [R8]
			end else begin
				duty_buf_q[dch][7:0] <= wb; // [R8]
			end
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < NUM_CH; i++) begin
				duty_act_q[i] <= '0;
			end
		end else if (wr && is_duty && !run) begin
			// Disabled: no cycle to wait for, so bypass the buffer [R13]
			if (dhi) begin
				duty_act_q[dch][11:8] <= wb[3:0];
			end else begin
				duty_act_q[dch][7:0] <= wb;
			end
		end else if (reload) begin
			for (int i = 0; i < NUM_CH; i++) begin
				duty_act_q[i] <= duty_buf_q[i]; // [R11]
			end
		end
	end
	// ****************************************
	// Read path
	// ****************************************
	always_comb begin
		rdata = 32'h0000_0000;
		if (is_duty) begin
			rdata[7:0] = dhi ? {4'h0, duty_buf_q[dch][11:8]} : duty_buf_q[dch][7:0];
		end else begin
			case (idx)
				IDX_CFG1: rdata[7:0] = {en_q, mode_q, scale_q};
				IDX_EVT: rdata[7:0] = {ztrg_en_q, ctrg_en_q, zint_en_q, cint_en_q, sync_gated_update_enable_q, 1'b0, zflag_q, cflag_q};
				IDX_DSP: rdata[7:0] = {prs_q, sync_q, pol_q}; // [R17]
				IDX_MASK: rdata[7:0] = {6'h00, mask_q};
				default: rdata = 32'h0000_0000;
			endcase
		end
	end
	// Answer captured in setup so data and error come from flops
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			prdata_out <= 32'h0000_0000;
			pslverr_out <= 1'b0;
		end else if (rd_setup) begin
			prdata_out <= pwrite_in ? 32'h0000_0000 : rdata;
			pslverr_out <= !mapped;
		end
	end
	// ****************************************
	// Channels
	// ****************************************
	cpwm_chan_if chif ();
	assign chif.cnt_s = cnt_s;
	assign chif.run = run;
	assign chif.res = mode_q;
	assign chif.dith_en = prs_q;
	assign chif.dith_sign = sign_q;
	assign chif.dith_odd = odd_q;
	for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		cpwm_chan u_chan (
			.clk_sys_in(clk_sys_in),
			.rst_n_in(rst_n_in),
			.ctl_in(chif.chan),
			.duty_in(duty_act_q[g]),
			.pol_in(pol_q[g]),
			.pwm_out(pwm_out[g])
		);
	end
	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	// A clear may follow the set at once, so only the set itself is checked here
	AST_ZFLAG: assert property (zero_evt && zint_en_q |=> zflag_q) else $error("zero flag not set"); // [R1] [R6]
	AST_CFLAG: assert property (ctr_evt && cint_en_q |=> cflag_q) else $error("centre flag not set"); // [R2] [R18]
	AST_ZTRIG: assert property (adc_zero_trig_out |-> $past(phase_q) == '0 && $past(tick)) // [R3]
		else $error("zero trigger off zero");
	AST_CTRIG: assert property (ctr_evt && ctrg_en_q |=> adc_center_trig_out ##1 !adc_center_trig_out) // [R3]
		else $error("centre trigger not one pulse");
	AST_HOLD: assert property (zero_evt && sync_gated_update_enable_q && !sync_q |=> $stable(duty_act_q[0])) // [R4]
		else $error("duty loaded without sync");
	AST_AUTO: assert property (zero_evt && !sync_gated_update_enable_q |=> duty_act_q[1] == $past(duty_buf_q[1])) // [R5] [R11]
		else $error("duty not loaded at cycle start");
	AST_SYNCCLR: assert property (zero_evt && sync_q && !sync_set |=> !sync_q) // [R17]
		else $error("sync not self-cleared");
	AST_IMM: assert property (wr && is_duty && !dhi && dch == 3'h0 && !run |=> duty_act_q[0][7:0] == $past(wb)) // [R13]
		else $error("disabled write not immediate");
	AST_WRAP: assert property (tick && phase_q == top |=> phase_q == '0) else $error("period wrong"); // [R15]
	AST_IRQ: assert property (zflag_q && mask_q[1] |-> ##1 irq_out) else $error("irq not raised"); // [R1]
	// Flags and sync hold until their own clear
	AST_ZHOLD: assert property (zflag_q && !(wr && idx == IDX_EVT && wb[EVT_ZF]) |=> zflag_q) // [R6]
		else $error("zero flag lost");
	AST_CHOLD: assert property (cflag_q && !(wr && idx == IDX_EVT && wb[EVT_CF]) |=> cflag_q) // [R18]
		else $error("centre flag lost");
	AST_SYNCHOLD: assert property (sync_q && !zero_evt |=> sync_q) // [R4] [R17]
		else $error("sync dropped before reload");
	// Disabled controller must restart from a clean count
	AST_OFFCLR: assert property (!run |=> phase_q == '0 && presc_q == 5'h00) // [R14]
		else $error("counter not cleared while disabled");
	AST_NOTRIG: assert property (!ztrg_en_q |=> !adc_zero_trig_out) else $error("zero trigger while off"); // [R3]
	COV_ZERO_LOAD: cover property (reload && sync_gated_update_enable_q);
	COV_CENTER: cover property (ctr_evt && cint_en_q);
	COV_DITHER: cover property (zero_evt && prs_q && sign_q);
	COV_SYNC_WAIT: cover property (zero_evt && sync_gated_update_enable_q && !sync_q);
endmodule : cpwm_top

// ### testbench/cpwm_pin_model.sv
// Pin-side model: counts high clocks of each channel over one PWM period
module cpwm_pin_model (
	input wire logic clk_sys_in,
	input wire logic [5:0] pwm_in,
	input wire logic zero_trig_in,
	output logic [5:0][13:0] hi_cnt_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0][13:0] acc_q;
	// ****************************************
	// High-time accumulators
	// ****************************************
	// Windows are bounded by zero triggers, so the first latched value is junk
	always_ff @(posedge clk_sys_in) begin
		for (int i = 0; i < 6; i++) begin
			if (zero_trig_in) begin
				hi_cnt_out[i] <= acc_q[i];
				acc_q[i] <= 14'(pwm_in[i]);
			end else begin
				acc_q[i] <= acc_q[i] + 14'(pwm_in[i]);
			end
		end
	end
endmodule : cpwm_pin_model

// ### testbench/test_center_pwm_duty_update_events.sv
// Testbench: registers, events, duty loading and pin behaviour of the PWM block
module test_center_pwm_duty_update_events;
	timeunit 1ns;
	timeprecision 1ps;
	import cpwm_pkg::*;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, adc_zero, adc_center;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [5:0] pwm;
	logic [5:0][13:0] hi_cnt;
	int mismatches, checked;
	// ****************************************
	// Instances and clock
	// ****************************************
	cpwm_top uut (.clk_sys_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .pwm_out(pwm), .irq_out(irq),
		.adc_zero_trig_out(adc_zero), .adc_center_trig_out(adc_center));
	cpwm_pin_model pins (.clk_sys_in(clk), .pwm_in(pwm), .zero_trig_in(adc_zero), .hi_cnt_out(hi_cnt));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d, output logic [32:0] r);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		r = {pslverr, prdata};
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 100) chk(32'h0, 32'h1);
	endtask : apb
	task automatic wr(input logic [15:0] idx, input logic [7:0] d);
		logic [32:0] r;
		apb(1'b1, idx, d, r);
	endtask : wr
	task automatic rd(input logic [15:0] idx, input logic [32:0] exp);
		logic [32:0] r;
		apb(1'b0, idx, 8'h00, r);
		chk(32'(r), 32'(exp));
		chk(32'(r[32]), 32'(exp[32]));
	endtask : rd
	task automatic wd(input int ch, input logic [11:0] v);
		wr(IDX_DUTY0 + 16'(2 * ch), v[7:0]);
		wr(IDX_DUTY0 + 16'(2 * ch + 1), {4'h0, v[11:8]});
	endtask : wd
	task automatic wait_zero(input int k);
		int n;
		n = 0;
		repeat (k) begin
			do begin
				@(posedge clk);
				n++;
			end while (adc_zero !== 1'b1 && n < 20000);
		end
		if (n >= 20000) chk(32'h0, 32'h1);
	endtask : wait_zero
	task automatic hi_chk(input int ch, input int exp);
		wait_zero(2);
		@(posedge clk);
		chk(32'(hi_cnt[ch]), 32'(exp));
	endtask : hi_chk
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs;
		rd(IDX_CFG1, 33'h00);
		rd(IDX_EVT, 33'h08);
		rd(IDX_DSP, 33'h00);
		rd(IDX_MASK, 33'h00);
		rd(16'hA0A0, 33'h100000000);
		wr(IDX_DSP, 8'h3F);
		rd(IDX_DSP, 33'h3F);
		wr(IDX_DSP, 8'h00);
		$display("test regs done");
	endtask : t_regs
	task automatic t_events;
		int n;
		n = 0;
		wr(IDX_EVT, 8'hF0);
		wr(IDX_MASK, 8'h00);
		wr(IDX_CFG1, 8'h80);
		wait_zero(1);
		rd(IDX_EVT, 33'hF2);
		chk(32'(irq), 32'h0);
		do begin
			@(posedge clk);
			n++;
		end while (adc_center !== 1'b1 && n < 600);
		chk(32'(n < 600), 32'h1);
		rd(IDX_EVT, 33'hF3);
		wr(IDX_MASK, 8'h03);
		repeat (3) @(posedge clk);
		chk(32'(irq), 32'h1);
		wr(IDX_EVT, 8'hF3);
		rd(IDX_EVT, 33'hF0);
		chk(32'(irq), 32'h0);
		wr(IDX_CFG1, 8'h00);
		wr(IDX_EVT, 8'h80);
		$display("test events done");
	endtask : t_events
	task automatic t_duty;
		wd(0, 12'h040);
		wd(1, 12'h0FF);
		wd(2, 12'h000);
		wd(3, 12'h140);
		rd(IDX_DUTY0 + 16'h0007, 33'h01);
		wd(4, 12'h000);
		wr(IDX_DSP, 8'h04);
		wr(IDX_CFG1, 8'h80);
		hi_chk(0, 128);
		chk(32'(hi_cnt[1]), 32'd510);
		chk(32'(hi_cnt[2]), 32'd512);
		chk(32'(hi_cnt[3]), 32'd128);
		chk(32'(hi_cnt[4]), 32'd0);
		wd(0, 12'h020);
		hi_chk(0, 64);
		wr(IDX_CFG1, 8'h00);
		repeat (2) @(posedge clk);
		chk(32'(pwm), 32'h0);
		wr(IDX_DSP, 8'h00);
		$display("test duty done");
	endtask : t_duty
	task automatic t_period;
		int n;
		int per [4] = '{PERIOD_8, PERIOD_10, PERIOD_12, 2 * PERIOD_8};
		logic [7:0] cfg [4] = '{8'h80, 8'hA0, 8'hC0, 8'h81};
		// Last entry runs the prescaler at divide-by-two
		for (int m = 0; m < 4; m++) begin
			n = 0;
			wr(IDX_CFG1, cfg[m]);
			wait_zero(1);
			do begin
				@(posedge clk);
				n++;
			end while (adc_zero !== 1'b1 && n < 9000);
			chk(32'(n), 32'(per[m]));
			wr(IDX_CFG1, 8'h00);
		end
		$display("test period done");
	endtask : t_period
	task automatic t_sync;
		wd(0, 12'h040);
		wr(IDX_EVT, 8'h88);
		wr(IDX_CFG1, 8'h80);
		wd(0, 12'h010);
		wait_zero(1);
		hi_chk(0, 128);
		wr(IDX_DSP, 8'h40);
		rd(IDX_DSP, 33'h40);
		hi_chk(0, 32);
		rd(IDX_DSP, 33'h00);
		wr(IDX_CFG1, 8'h00);
		wr(IDX_EVT, 8'h80);
		$display("test sync done");
	endtask : t_sync
	task automatic t_dither;
		int a;
		wd(0, 12'h040);
		wr(IDX_DSP, 8'h80);
		wr(IDX_CFG1, 8'h80);
		// First cycle after enable is unpaired; the pair is cycles two and three
		wait_zero(3);
		@(posedge clk);
		a = hi_cnt[0];
		chk(32'(a == 128 || a == 130), 32'h1);
		wait_zero(1);
		@(posedge clk);
		chk(32'(a + hi_cnt[0]), 32'd256);
		wr(IDX_CFG1, 8'h00);
		wr(IDX_DSP, 8'h00);
		$display("test dither done");
	endtask : t_dither
	// ****************************************
	// Sequence, watchdog and verdict
	// ****************************************
	task automatic stop_test;
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test
	initial begin
		mismatches = 0;
		checked = 0;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_events();
		t_duty();
		t_period();
		t_sync();
		t_dither();
		stop_test();
	end
	initial begin
		#900000;
		mismatches++;
		stop_test();
	end
endmodule : test_center_pwm_duty_update_events
